/* File: rtl/lbo_sequencer.sv */
// Host-side sequencer for lock-bit set/clear, OTP program and status handling
`include "lbo_consts.svh"

// What this block does
// - Issue read-status before and after each lock-set, lock-clear or OTP operation; poll ready bit until 1.
// - Lock set: setup code then 01H at block or F1H at device address.
// - Clear locks: setup code then clear-confirm code, any address.
// - OTP: setup code, then data word at its target location.
// - After any error, host issues status-clear before retry; the sequencer sends it only on an LBO_OP_CLEAR_STATUS request, never by itself.
// - After final operation, host writes read-array code; the sequencer sends it only on an LBO_OP_READ_ARRAY request, never by itself.
module lbo_sequencer
	import lbo_pkg::*;
(
	input  wire logic        clk,           // 125 MHz clock
	input  wire logic        rst_n,         // sync reset, active low
	input  wire logic        cmd_valid,     // operation request
	output logic             cmd_ready,     // sequencer idle
	input  wire lbo_op_t     cmd_op,        // requested operation
	input  wire logic [19:0] cmd_addr,      // block, device or OTP address
	input  wire logic [15:0] cmd_data,      // OTP data word
	input  wire logic        hold_reset,    // request device reset
	output logic             rsp_valid,     // operation finished, one cycle
	output logic [7:0]       rsp_status,    // final status byte
	output logic             rsp_error,     // any error bit seen
	output logic             rsp_seq_err,   // invalid command sequence
	output logic             rsp_protect,   // permanent lock refusal
	output logic             rsp_supply,    // supply error
	output logic             rsp_op_fail,   // set or clear failure
	output logic             rsp_retry_ok,  // status cleared after error
	output logic             engine_busy,   // ready_busy_output seen low
	output logic [19:0]      flash_addr,    // address pins
	output logic             flash_ce_n,    // chip enable
	output logic             flash_we_n,    // write enable
	output logic             flash_oe_n,    // output enable
	output logic [15:0]      flash_dq_o,    // data out
	output logic             flash_dq_oe,   // data drive enable
	input  wire logic [15:0] flash_dq_i,    // data in
	input  wire logic        ready_busy_output, // open-drain ready line
	output logic             reset_powerdown_input // drives device reset, low active
);
	typedef enum logic [3:0]
	{
		S_IDLE, S_PRE_STAT, S_PRE_POLL, S_SETUP, S_CONFIRM,
		S_POST_STAT, S_POST_POLL, S_CLR, S_ARRAY, S_DONE
	} lbo_seq_t;

	lbo_bus_if bus();

	lbo_seq_t    state, next_state;
	lbo_op_t     op, next_op;
	logic [19:0] addr, next_addr;
	logic [15:0] data, next_data;
	logic [7:0]  status, next_status;
	logic        issued, next_issued;
	logic        cleared, next_cleared;
	logic [15:0] dq_s1, dq_s2;
	logic        rb_s1, rb_s2;
	logic        cyc_rst_n;

	// Open-drain ready line and data bus through two flops each
	always_ff @(posedge clk)
	begin
		dq_s1 <= flash_dq_i;
		dq_s2 <= dq_s1;
		rb_s1 <= ready_busy_output;
		rb_s2 <= rb_s1;
	end

	function automatic logic has_error(input logic [7:0] s);
		has_error = s[`LBO_CLRFAIL_POS] | s[`LBO_SETFAIL_POS] | s[`LBO_SUPPLY_POS] | s[`LBO_PROTECT_POS];
	endfunction

	function automatic logic is_config(input lbo_op_t o);
		is_config = (o == LBO_OP_SET_BLOCK) || (o == LBO_OP_SET_PERM) || (o == LBO_OP_CLEAR_LOCKS) || (o == LBO_OP_OTP);
	endfunction

	always_comb
	begin
		next_state   = state;
		next_op      = op;
		next_addr    = addr;
		next_data    = data;
		next_status  = status;
		next_issued  = issued;
		next_cleared = cleared;
		bus.req   = 1'b0;
		bus.wr    = 1'b1;
		bus.addr  = 20'h00000;
		bus.wdata = 16'h0000;
		unique case (state)
			S_IDLE:
				if (cmd_valid)
				begin
					next_op      = cmd_op;
					next_addr    = cmd_addr;
					next_data    = cmd_data;
					next_cleared = 1'b0;
					next_issued  = 1'b0;
					unique case (cmd_op)
						LBO_OP_CLEAR_STATUS: next_state = S_CLR;
						LBO_OP_READ_ARRAY:   next_state = S_ARRAY;
						LBO_OP_READ_STATUS:  next_state = S_POST_STAT;
						default:             next_state = S_PRE_STAT;
					endcase
				end
			S_PRE_STAT, S_POST_STAT:
			begin
				bus.req   = !issued;
				bus.wdata = {8'h00, `LBO_CMD_READ_STATUS};
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued = 1'b0;
					next_state  = (state == S_PRE_STAT) ? S_PRE_POLL : S_POST_POLL;
				end
			end
			S_PRE_POLL, S_POST_POLL:
			begin
				bus.req = !issued;
				bus.wr  = 1'b0;
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued = 1'b0;
					next_status = bus.rdata[7:0];
					if (bus.rdata[`LBO_READY_POS])
						next_state = (state == S_PRE_POLL) ? S_SETUP : S_DONE;
				end
			end
			S_SETUP:
			begin
				bus.req   = !issued;
				bus.wdata = {8'h00, (op == LBO_OP_OTP) ? `LBO_CMD_OTP_SETUP : `LBO_CMD_LOCK_SETUP};
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued = 1'b0;
					next_state  = S_CONFIRM;
				end
			end
			S_CONFIRM:
			begin
				bus.req  = !issued;
				bus.addr = addr;
				unique case (op)
					LBO_OP_SET_BLOCK: bus.wdata = {8'h00, `LBO_CMD_BLOCK_CONFIRM};
					LBO_OP_SET_PERM:  bus.wdata = {8'h00, `LBO_CMD_PERM_CONFIRM};
					LBO_OP_CLEAR_LOCKS: bus.wdata = {8'h00, `LBO_CMD_CLEAR_CONFIRM};
					default: bus.wdata = data;
				endcase
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued = 1'b0;
					next_state  = S_POST_STAT;
				end
			end
			S_CLR:
			begin
				bus.req   = !issued;
				bus.wdata = {8'h00, `LBO_CMD_CLEAR_STATUS};
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued  = 1'b0;
					next_cleared = 1'b1;
					next_status  = 8'h00;
					next_state   = S_DONE;
				end
			end
			S_ARRAY:
			begin
				bus.req   = !issued;
				bus.wdata = {8'h00, `LBO_CMD_READ_ARRAY};
				next_issued = 1'b1;
				if (bus.done)
				begin
					next_issued = 1'b0;
					next_state  = S_DONE;
				end
			end
			S_DONE:
				next_state = S_IDLE;
			default:
				next_state = S_IDLE;
		endcase
		if (hold_reset)
			next_state = S_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state   <= S_IDLE;
			op      <= LBO_OP_READ_STATUS;
			addr    <= 20'h00000;
			data    <= 16'h0000;
			status  <= 8'h00;
			issued  <= 1'b0;
			cleared <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			op      <= next_op;
			addr    <= next_addr;
			data    <= next_data;
			status  <= next_status;
			issued  <= next_issued;
			cleared <= next_cleared;
		end
	end

	lbo_bus_cycle u_cycle
	(
		.clk           (clk),
		.rst_n         (cyc_rst_n),
		.bus           (bus.eng),
		.flash_addr    (flash_addr),
		.flash_ce_n    (flash_ce_n),
		.flash_we_n    (flash_we_n),
		.flash_oe_n    (flash_oe_n),
		.flash_dq_o    (flash_dq_o),
		.flash_dq_oe   (flash_dq_oe),
		.flash_dq_sync (dq_s2)
	);

	// device reset also cuts any bus cycle in flight
	assign cyc_rst_n = rst_n && !hold_reset;

	assign engine_busy = !rb_s2;
	assign reset_powerdown_input = !(hold_reset || !rst_n);
	assign cmd_ready   = (state == S_IDLE) && !hold_reset;
	assign rsp_valid   = (state == S_DONE);
	assign rsp_status  = status;
	assign rsp_error   = has_error(status);
	assign rsp_seq_err = status[`LBO_CLRFAIL_POS] & status[`LBO_SETFAIL_POS];
	assign rsp_protect = status[`LBO_PROTECT_POS];
	assign rsp_supply  = status[`LBO_SUPPLY_POS];
	assign rsp_op_fail = status[`LBO_CLRFAIL_POS] ^ status[`LBO_SETFAIL_POS];
	assign rsp_retry_ok = cleared && !is_config(op);
endmodule

/* File: rtl/lbo_consts.svh */
// Command codes, status bit positions and bus timing counts for the lock/OTP sequencer
`ifndef LBO_CONSTS_SVH
`define LBO_CONSTS_SVH

`define LBO_CMD_READ_STATUS   8'h70
`define LBO_CMD_LOCK_SETUP    8'h60
`define LBO_CMD_BLOCK_CONFIRM 8'h01
`define LBO_CMD_PERM_CONFIRM  8'hF1
`define LBO_CMD_CLEAR_CONFIRM 8'hD0
`define LBO_CMD_OTP_SETUP     8'hC0
`define LBO_CMD_CLEAR_STATUS  8'h50
`define LBO_CMD_READ_ARRAY    8'hFF

`define LBO_READY_POS   7
`define LBO_CLRFAIL_POS 5
`define LBO_SETFAIL_POS 4
`define LBO_SUPPLY_POS  3
`define LBO_PROTECT_POS 1

// Strobe low time and bus turnaround, in bus clock cycles
`define LBO_STROBE_CYC  4'h4
`define LBO_GAP_CYC     4'h2
`define LBO_READ_CYC    4'h6

`endif

/* File: rtl/lbo_pkg.sv */
// Types for the lock-bit and OTP command sequencer
package lbo_pkg;
	typedef enum logic [2:0]
	{
		LBO_OP_SET_BLOCK,
		LBO_OP_SET_PERM,
		LBO_OP_CLEAR_LOCKS,
		LBO_OP_OTP,
		LBO_OP_CLEAR_STATUS,
		LBO_OP_READ_ARRAY,
		LBO_OP_READ_STATUS
	} lbo_op_t;

	typedef enum logic [1:0]
	{
		LBO_CYC_IDLE,
		LBO_CYC_ACTIVE,
		LBO_CYC_GAP
	} lbo_cyc_t;
endpackage

/* File: rtl/lbo_bus_if.sv */
// Single-cycle request/answer carrier between the sequencer and its bus cycle engine
interface lbo_bus_if;
	logic        req;
	logic        wr;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;

	modport seq
	(
		output req, wr, addr, wdata,
		input  done, rdata
	);
	modport eng
	(
		input  req, wr, addr, wdata,
		output done, rdata
	);
endinterface

/* File: rtl/lbo_bus_cycle.sv */
// Drives one write or read cycle on the flash pins
`include "lbo_consts.svh"
module lbo_bus_cycle
	import lbo_pkg::*;
(
	input  wire logic clk,             // bus clock
	input  wire logic rst_n,           // sync reset
	lbo_bus_if.eng    bus,             // request from the sequencer
	output logic [19:0] flash_addr,    // address pins
	output logic        flash_ce_n,    // chip enable
	output logic        flash_we_n,    // write enable
	output logic        flash_oe_n,    // output enable
	output logic [15:0] flash_dq_o,    // data out
	output logic        flash_dq_oe,   // data drive enable
	input  wire logic [15:0] flash_dq_sync // data in, already synchronised
);
	lbo_cyc_t    state, next_state;
	logic [3:0]  cnt, next_cnt;
	logic        wr, next_wr;
	logic [19:0] next_addr;
	logic [15:0] next_dq, rdata, next_rdata;

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		next_wr    = wr;
		next_addr  = flash_addr;
		next_dq    = flash_dq_o;
		next_rdata = rdata;
		unique case (state)
			LBO_CYC_IDLE:
				if (bus.req)
				begin
					next_state = LBO_CYC_ACTIVE;
					next_wr    = bus.wr;
					next_addr  = bus.addr;
					next_dq    = bus.wdata;
					next_cnt   = bus.wr ? `LBO_STROBE_CYC : `LBO_READ_CYC;
				end
			LBO_CYC_ACTIVE:
				if (cnt == 4'h1)
				begin
					next_state = LBO_CYC_GAP;
					next_cnt   = `LBO_GAP_CYC;
					next_rdata = flash_dq_sync;
				end
				else
					next_cnt = cnt - 4'h1;
			LBO_CYC_GAP:
				if (cnt == 4'h1)
					next_state = LBO_CYC_IDLE;
				else
					next_cnt = cnt - 4'h1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state      <= LBO_CYC_IDLE;
			cnt        <= 4'h0;
			wr         <= 1'b0;
			flash_addr <= 20'h00000;
			flash_dq_o <= 16'h0000;
			rdata      <= 16'h0000;
		end
		else
		begin
			state      <= next_state;
			cnt        <= next_cnt;
			wr         <= next_wr;
			flash_addr <= next_addr;
			flash_dq_o <= next_dq;
			rdata      <= next_rdata;
		end
	end

	assign flash_ce_n  = !(state == LBO_CYC_ACTIVE);
	assign flash_we_n  = !(state == LBO_CYC_ACTIVE && wr);
	assign flash_oe_n  = !(state == LBO_CYC_ACTIVE && !wr);
	assign flash_dq_oe = (state != LBO_CYC_IDLE) && wr;
	assign bus.done    = (state == LBO_CYC_GAP) && (cnt == 4'h1);
	assign bus.rdata   = rdata;
endmodule

/* File: test/lbo_sequencer_asserts.sv */
// Port assertions for the lock/OTP sequencer
module lbo_chk
(
	input wire logic       clk,                   // clock
	input wire logic       rst_n,                 // sync reset
	input wire logic       cmd_ready,             // idle
	input wire logic       hold_reset,            // reset request
	input wire logic       rsp_valid,             // done pulse
	input wire logic [7:0] rsp_status,            // status byte
	input wire logic       rsp_seq_err,           // sequence error
	input wire logic       flash_ce_n,            // chip enable
	input wire logic       flash_we_n,            // write enable
	input wire logic       flash_oe_n,            // output enable
	input wire logic       flash_dq_oe,           // data drive
	input wire logic       reset_powerdown_input  // device reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	rst_pin_a: assert property (hold_reset |-> !reset_powerdown_input) else $error("reset pin high");
	rst_idle_a: assert property (hold_reset |-> !cmd_ready) else $error("ready in reset");
	seq_dec_a: assert property (rsp_valid |-> rsp_seq_err == (rsp_status[5] && rsp_status[4]))
		else $error("bad decode");
	we_sel_a: assert property (!flash_we_n |-> !flash_ce_n) else $error("write unselected");
	oe_drive_a: assert property (!flash_oe_n |-> !flash_dq_oe) else $error("bus contention");
	we_len_a: assert property (disable iff (!rst_n || hold_reset) $fell(flash_we_n) |-> !flash_we_n[*4] ##1 flash_we_n)
		else $error("write strobe length");
	oe_len_a: assert property (disable iff (!rst_n || hold_reset) $fell(flash_oe_n) |-> !flash_oe_n[*6] ##1 flash_oe_n)
		else $error("read strobe length");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("long done");
endmodule

/* File: test/lbo_flash_model.sv */
// Behavioural flash device behind the sequencer's pins
module lbo_flash_model
(
	input  wire logic        clk,   // bench clock
	input  wire logic        ce_n,  // chip enable
	input  wire logic        we_n,  // write enable
	input  wire logic        oe_n,  // output enable
	input  wire logic [15:0] dq,    // host data
	input  wire logic [19:0] addr,  // address pins
	input  wire logic        rp_n,  // device reset
	input  wire logic        sup,   // supply bad
	input  wire logic        sfail, // set fails
	input  wire logic        cfail, // clear fails
	input  wire logic        perm,  // permanent lock
	input  wire logic        bad,   // garble confirm
	output logic [15:0]      dq_i,  // data to host
	output logic             rb     // pulled-up ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  st = 8'h00;
	logic [7:0]  mode = 8'hFF;
	logic [7:0]  wd = 8'h00;
	logic [19:0] ca = 20'h00000;
	logic [15:0] cd = 16'h0000;
	logic        we_q = 1'b1;
	logic        clr;
	logic        cfg;
	logic [15:0] rd;
	int          busy = 0;
	assign clr = (mode == 8'h60) && (wd == 8'hD0);
	assign cfg = (mode == 8'h60) || (mode == 8'hC0);
	assign rb = (busy == 0);
	assign rd = (mode == 8'hFF) ? 16'h0000 : {8'h00, busy == 0, st[6:0]};
	assign dq_i = (!ce_n && !oe_n) ? rd : ~rd;
	always @(posedge clk)
	begin
		we_q <= we_n;
		if (!we_n && !ce_n)
			wd <= dq[7:0];
		if (busy > 0)
			busy <= busy - 1;
		if (!rp_n)
		begin
			st <= 8'h00;
			mode <= 8'hFF;
			busy <= 0;
		end
		else if (we_n && !we_q)
		begin
			if (mode == 8'h60 && (bad || !(wd == 8'h01 || wd == 8'hF1 || wd == 8'hD0)))
				st[5:4] <= 2'b11;
			else if (cfg)
			begin
				busy <= (mode == 8'hC0) ? 3 : 9;
				// confirm address and data kept for the bench
				ca <= addr;
				cd <= dq;
				if (sup)
					st <= st | (clr ? 8'h28 : 8'h18);
				else if (perm && !clr)
					st[1] <= 1'b1;
				else if (clr ? cfail : sfail)
					st <= st | (clr ? 8'h20 : 8'h10);
			end
			else if (wd == 8'h50)
				st <= 8'h00;
			mode <= cfg ? 8'h70 : wd;
		end
	end
endmodule

/* File: test/lbo_sequencer_tb.sv */
// Self-checking bench for the lock/OTP sequencer
module lbo_sequencer_tb
	import lbo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, cmd_valid = 0, hold_reset = 0;
	logic        sup = 0, sfail = 0, cfail = 0, perm = 0, bad = 0, seen;
	lbo_op_t     cmd_op = LBO_OP_READ_STATUS;
	logic [19:0] cmd_addr = 20'h00000, flash_addr;
	logic [15:0] cmd_data = 16'h5AA5, flash_dq_o, flash_dq_i;
	logic [7:0]  rsp_status;
	logic        cmd_ready, rsp_valid, rsp_error, rsp_seq_err, rsp_protect, rsp_supply;
	logic        rsp_op_fail, rsp_retry_ok, engine_busy, flash_ce_n, flash_we_n, flash_oe_n;
	logic        flash_dq_oe, ready_busy_output, reset_powerdown_input;
	int          num_errors = 0;
	int          checks_done = 0;
	lbo_sequencer u_dut (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
		.hold_reset, .rsp_valid, .rsp_status, .rsp_error, .rsp_seq_err, .rsp_protect, .rsp_supply,
		.rsp_op_fail, .rsp_retry_ok, .engine_busy, .flash_addr, .flash_ce_n, .flash_we_n,
		.flash_oe_n, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .ready_busy_output,
		.reset_powerdown_input);
	lbo_flash_model u_dev (.clk, .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
		.dq(flash_dq_o), .addr(flash_addr), .rp_n(reset_powerdown_input), .sup, .sfail, .cfail, .perm, .bad,
		.dq_i(flash_dq_i), .rb(ready_busy_output));
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_w(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run(input lbo_op_t op, input logic [19:0] a);
		int n;
		n = 0;
		@(negedge clk);
		seen = 1'b0;
		cmd_op = op;
		cmd_addr = a;
		cmd_valid = 1'b1;
		while (!cmd_ready && n < 99)
		begin
			@(negedge clk);
			n++;
		end
		if (!cmd_ready)
		begin
			num_errors++;
			conclude();
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			seen |= engine_busy;
			n++;
		end
		if (rsp_valid !== 1'b1)
		begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic t_clr();
		run(LBO_OP_CLEAR_STATUS, 20'h00000);
		cmp(rsp_status, 8'h00);
		cmp(rsp_retry_ok, 1'b1);
	endtask
	task automatic t_set();
		run(LBO_OP_SET_BLOCK, 20'h18000);
		cmp(rsp_status, 8'h80);
		cmp(seen, 1'b1);
		cmp_w(u_dev.ca, 20'h18000);
		cmp(rsp_retry_ok, 1'b0);
	endtask
	task automatic t_sticky();
		sfail = 1'b1;
		run(LBO_OP_SET_PERM, 20'h00000);
		sfail = 1'b0;
		cmp(rsp_status, 8'h90);
		run(LBO_OP_CLEAR_LOCKS, 20'h00000);
		cmp(rsp_status, 8'h90);
		cmp(rsp_op_fail, 1'b1);
		cmp(rsp_error, 1'b1);
		t_clr();
	endtask
	task automatic t_clrf();
		cfail = 1'b1;
		run(LBO_OP_CLEAR_LOCKS, 20'h00000);
		cfail = 1'b0;
		cmp(rsp_status, 8'hA0);
		t_clr();
	endtask
	task automatic t_sup();
		sup = 1'b1;
		run(LBO_OP_OTP, 20'h00102);
		cmp(rsp_status, 8'h98);
		run(LBO_OP_CLEAR_LOCKS, 20'h00000);
		sup = 1'b0;
		cmp(rsp_status, 8'hB8);
		cmp(rsp_supply, 1'b1);
		t_clr();
	endtask
	task automatic t_prot();
		perm = 1'b1;
		run(LBO_OP_SET_BLOCK, 20'h20000);
		perm = 1'b0;
		cmp(rsp_status, 8'h82);
		cmp(rsp_protect, 1'b1);
		t_clr();
	endtask
	task automatic t_bad();
		bad = 1'b1;
		run(LBO_OP_SET_BLOCK, 20'h08000);
		bad = 1'b0;
		cmp(rsp_status, 8'hB0);
		cmp(rsp_seq_err, 1'b1);
		t_clr();
	endtask
	task automatic t_otp();
		run(LBO_OP_OTP, 20'h00104);
		cmp(rsp_status, 8'h80);
		cmp_w(u_dev.ca, 20'h00104);
		cmp_w(u_dev.cd, 20'h05AA5);
		run(LBO_OP_READ_ARRAY, 20'h00000);
		cmp(u_dev.mode, 8'hFF);
	endtask
	task automatic t_rst();
		sfail = 1'b1;
		run(LBO_OP_SET_BLOCK, 20'h10000);
		sfail = 1'b0;
		@(negedge clk);
		hold_reset = 1'b1;
		@(negedge clk);
		cmp(reset_powerdown_input, 1'b0);
		cmp(cmd_ready, 1'b0);
		repeat (2) @(negedge clk);
		hold_reset = 1'b0;
		run(LBO_OP_READ_STATUS, 20'h00000);
		cmp(rsp_status, 8'h80);
	endtask
	initial
	begin
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		t_set();
		t_sticky();
		t_clrf();
		t_sup();
		t_prot();
		t_bad();
		t_otp();
		t_rst();
		conclude();
	end
endmodule
bind lbo_sequencer lbo_chk u_chk (.clk, .rst_n, .cmd_ready, .hold_reset, .rsp_valid, .rsp_status,
	.rsp_seq_err, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe, .reset_powerdown_input);
